// ---- system_address_map_decoder.sv ----
// system address decoder with region attribute and access checks
// ------------------------------------------------------------
// Notes on behaviour
// - lowest half-gigabyte is code region, vectors at address zero
// - second data window has no memory behind it
// - peripheral window holds peripheral registers, no fetches, no bit-band
// - private window goes to core-internal registers
// - 128 KB boot ROM sits at the bottom
// - SRAM up to 288 KB in its code-region window
// - 1 MB main flash in 256 KB sectors at its base
// - 32 KB auxiliary flash window
// - 32 KB supervisory flash window
// - supervisory flash cannot change once lifecycle is secure
// - flash reads 128 bits wide, writes per 512-byte row
// - flash reads in any mode, no writes in ultra-low-power
// - ROM fetch only by secondary processor in context zero
// - system-function request raises NMI in secondary processor
// - 1024-bit fuse array, 512 system bits, bits only set
// - eight contexts, boot context sets rights per master and level
// - both processors see the same map
// - SRAM retention per 32 KB block, nothing kept in hibernate
// ------------------------------------------------------------
`timescale 1ns/1ps
`include "addr_map_defines.svh"

module system_address_map_decoder #(
	parameter int SRAM_BLOCKS = `SRAM_BLOCKS
) (
	input  wire logic                     ref_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     req_valid,
	input  wire logic [31:0]              req_addr,
	input  wire logic                     req_write,
	input  wire logic                     req_fetch,
	input  wire addr_map_pkg::master_t    req_master,
	input  wire logic [2:0]               req_context,
	input  wire logic                     req_priv,
	input  wire logic                     ultra_low_power_mode,
	input  wire logic                     lifecycle_secure,
	input  wire logic                     deep_sleep,
	input  wire logic                     hibernate,
	input  wire logic [SRAM_BLOCKS-1:0]   sram_retain_mask,
	input  wire logic                     sf_req_primary,
	input  wire logic                     sf_req_secondary,
	input  wire logic                     sf_req_debug,
	input  wire logic                     sf_done,
	input  wire logic                     cfg_valid,
	input  wire logic [2:0]               cfg_context,
	input  wire addr_map_pkg::master_t    cfg_master,
	input  wire logic                     cfg_priv,
	input  wire logic [2:0]               cfg_rights,
	input  wire logic                     fuse_prog_valid,
	input  wire logic [9:0]               fuse_prog_index,
	input  wire logic [9:0]               fuse_rd_index,
	output logic                          rsp_valid,
	output logic                          rsp_error,
	output addr_map_pkg::target_t         rsp_target,
	output addr_map_pkg::fault_t          rsp_fault,
	output logic [31:0]                   rsp_offset,
	output logic [27:0]                   flash_line,
	output logic                          nmi_secondary,
	output logic                          sf_busy,
	output logic [SRAM_BLOCKS-1:0]        sram_block_on,
	output logic                          fuse_rd_bit
);
	localparam logic [31:0] ROW_MASK = 32'(`FLASH_ROW_BYTES - 1);
	localparam int LINE_SHIFT = $clog2(`FLASH_LINE_BITS / 8);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic [2:0]              rights;
	addr_map_pkg::target_t   tgt;
	addr_map_pkg::fault_t    flt;
	logic [31:0]             base;
	logic                    is_flash;

	logic                    rsp_valid_next;
	logic                    rsp_error_next;
	addr_map_pkg::target_t   rsp_target_next;
	addr_map_pkg::fault_t    rsp_fault_next;
	logic [31:0]             rsp_offset_next;
	logic [27:0]             flash_line_next;

	context_rights_table u_rights (
		.ref_clk         (ref_clk),
		.sys_rst         (sys_rst),
		.cfg_valid       (cfg_valid),
		.cfg_src_context (req_context),
		.cfg_context     (cfg_context),
		.cfg_master      (cfg_master),
		.cfg_priv        (cfg_priv),
		.cfg_rights      (cfg_rights),
		.look_context    (req_context),
		.look_master     (req_master),
		.look_priv       (req_priv),
		.look_rights     (rights)
	);

	fuse_array_otp u_fuse (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.prog_valid    (fuse_prog_valid),
		.prog_boot_ctx (req_context == `BOOT_CONTEXT),
		.prog_index    (fuse_prog_index),
		.rd_index      (fuse_rd_index),
		.rd_bit        (fuse_rd_bit)
	);

	// ------------------------------------------------------------
	// region decode
	// ------------------------------------------------------------
	// decode ignores master
	always_comb begin
		tgt  = addr_map_pkg::TGT_NONE;
		base = 32'h0;
		if (req_addr <= `CODE_LAST) begin
			if (req_addr <= `ROM_LAST) begin
				tgt  = addr_map_pkg::TGT_ROM;
				base = `ROM_BASE;
			end else if (req_addr >= `SRAM_BASE
			             && req_addr <= `SRAM_LAST) begin
				tgt  = addr_map_pkg::TGT_SRAM;
				base = `SRAM_BASE;
			end else if (req_addr >= `MFLASH_BASE
			             && req_addr <= `MFLASH_LAST) begin
				tgt  = addr_map_pkg::TGT_MFLASH;
				base = `MFLASH_BASE;
			end else if (req_addr >= `AFLASH_BASE
			             && req_addr <= `AFLASH_LAST) begin
				tgt  = addr_map_pkg::TGT_AFLASH;
				base = `AFLASH_BASE;
			end else if (req_addr >= `SUPFLASH_BASE
			             && req_addr <= `SUPFLASH_LAST) begin
				tgt  = addr_map_pkg::TGT_SUPFLASH;
				base = `SUPFLASH_BASE;
			end
		end else if (req_addr >= `PERI_BASE && req_addr <= `PERI_LAST) begin
			tgt  = addr_map_pkg::TGT_PERIPH;
			base = `PERI_BASE;
		end else if (req_addr >= `EXT_BASE && req_addr <= `EXT_LAST) begin
			tgt  = addr_map_pkg::TGT_SERIAL;
			base = `EXT_BASE;
		end else if (req_addr >= `PPB_BASE && req_addr <= `PPB_LAST) begin
			tgt  = addr_map_pkg::TGT_PRIVATE;
			base = `PPB_BASE;
		end else if (req_addr >= `SYS_BASE) begin
			tgt  = addr_map_pkg::TGT_SYSREG;
			base = `SYS_BASE;
		end
	end

	assign is_flash = tgt == addr_map_pkg::TGT_MFLASH
	               || tgt == addr_map_pkg::TGT_AFLASH
	               || tgt == addr_map_pkg::TGT_SUPFLASH;

	// ------------------------------------------------------------
	// attribute checks, earlier tests win
	// ------------------------------------------------------------
	always_comb begin
		flt = addr_map_pkg::FLT_NONE;
		if (tgt == addr_map_pkg::TGT_NONE) begin
			flt = addr_map_pkg::FLT_UNMAPPED;
		end else if (req_fetch && tgt == addr_map_pkg::TGT_PERIPH) begin
			flt = addr_map_pkg::FLT_EXEC;
		end else if (req_fetch && tgt == addr_map_pkg::TGT_ROM
		             && !(req_master == addr_map_pkg::MST_SECONDARY
		                  && req_context == `BOOT_CONTEXT)) begin
			flt = addr_map_pkg::FLT_ROM_EXEC;
		end else if ((req_fetch && !rights[2])
		             || (req_write && !rights[1])
		             || (!req_fetch && !req_write && !rights[0])) begin
			flt = addr_map_pkg::FLT_RIGHTS;
		end else if (req_write && tgt == addr_map_pkg::TGT_SUPFLASH
		             && lifecycle_secure) begin
			flt = addr_map_pkg::FLT_SUP_LOCK;
		// no flash write at low voltage
		end else if (req_write && is_flash && ultra_low_power_mode) begin
			flt = addr_map_pkg::FLT_LOW_VOLT;
		end else if (req_write && is_flash
		             && (req_addr & ROW_MASK) != 32'h0) begin
			flt = addr_map_pkg::FLT_ROW;
		end
	end

	// ------------------------------------------------------------
	// response register, one cycle after the request
	// ------------------------------------------------------------
	always_comb begin
		rsp_valid_next  = req_valid;
		rsp_error_next  = 1'b0;
		rsp_target_next = addr_map_pkg::TGT_NONE;
		rsp_fault_next  = addr_map_pkg::FLT_NONE;
		rsp_offset_next = 32'h0;
		flash_line_next = flash_line;
		if (req_valid) begin
			rsp_error_next  = flt != addr_map_pkg::FLT_NONE;
			rsp_fault_next  = flt;
			rsp_target_next = (flt == addr_map_pkg::FLT_NONE)
			                ? tgt : addr_map_pkg::TGT_NONE;
			rsp_offset_next = (flt == addr_map_pkg::FLT_NONE)
			                ? req_addr - base : 32'h0;
			if (is_flash && flt == addr_map_pkg::FLT_NONE) begin
				flash_line_next = 28'(req_addr >> LINE_SHIFT);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rsp_valid  <= 1'b0;
			rsp_error  <= 1'b0;
			rsp_target <= addr_map_pkg::TGT_NONE;
			rsp_fault  <= addr_map_pkg::FLT_NONE;
			rsp_offset <= 32'h0;
			flash_line <= 28'h0;
		end else begin
			rsp_valid  <= rsp_valid_next;
			rsp_error  <= rsp_error_next;
			rsp_target <= rsp_target_next;
			rsp_fault  <= rsp_fault_next;
			rsp_offset <= rsp_offset_next;
			flash_line <= flash_line_next;
		end
	end

	// ------------------------------------------------------------
	// system-function request handshake
	// ------------------------------------------------------------
	addr_map_pkg::sf_state_t sf_state_reg;
	addr_map_pkg::sf_state_t sf_state_next;
	logic                    sf_any;
	logic                    nmi_next;
	logic                    busy_next;

	assign sf_any = sf_req_primary | sf_req_secondary | sf_req_debug;

	// requests during a run are dropped; callers poll sf_busy first
	// NMI on request
	always_comb begin
		sf_state_next = sf_state_reg;
		unique case (sf_state_reg)
			addr_map_pkg::SF_IDLE: begin
				if (sf_any) begin
					sf_state_next = addr_map_pkg::SF_NMI;
				end
			end
			addr_map_pkg::SF_NMI: begin
				sf_state_next = addr_map_pkg::SF_RUN;
			end
			addr_map_pkg::SF_RUN: begin
				if (sf_done) begin
					sf_state_next = addr_map_pkg::SF_IDLE;
				end
			end
			default: begin
				sf_state_next = addr_map_pkg::SF_IDLE;
			end
		endcase
		nmi_next  = sf_state_next == addr_map_pkg::SF_NMI;
		busy_next = sf_state_next != addr_map_pkg::SF_IDLE;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sf_state_reg  <= addr_map_pkg::SF_IDLE;
			nmi_secondary <= 1'b0;
			sf_busy       <= 1'b0;
		end else begin
			sf_state_reg  <= sf_state_next;
			nmi_secondary <= nmi_next;
			sf_busy       <= busy_next;
		end
	end

	// ------------------------------------------------------------
	// SRAM block power and retention
	// ------------------------------------------------------------
	logic [SRAM_BLOCKS-1:0] sram_on_next;

	always_comb begin
		if (hibernate) begin
			sram_on_next = '0;
		end else if (deep_sleep) begin
			sram_on_next = sram_retain_mask;
		end else begin
			sram_on_next = '1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sram_block_on <= '1;
		end else begin
			sram_block_on <= sram_on_next;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_sf_start;
		sf_state_reg == addr_map_pkg::SF_IDLE && sf_any;
	endsequence
	sequence s_nmi_pulse;
		nmi_secondary ##1 (!nmi_secondary && sf_busy);
	endsequence
	chk_sf_nmi_pulse: assert property (s_sf_start |=> s_nmi_pulse)
		else $error("system function did not give one nmi pulse");
	chk_periph_no_fetch: assert property (req_valid && req_fetch
		&& req_addr >= `PERI_BASE && req_addr <= `PERI_LAST
		|=> rsp_error && rsp_fault == addr_map_pkg::FLT_EXEC)
		else $error("fetch from peripheral space not refused");
	chk_data_gap_err: assert property (req_valid
		&& req_addr >= `DATA_BASE && req_addr <= `DATA_LAST
		|=> rsp_error && rsp_target == addr_map_pkg::TGT_NONE)
		else $error("data window access did not error");
	chk_rom_fetch_gate: assert property (rsp_valid && !rsp_error
		&& $past(req_fetch) && rsp_target == addr_map_pkg::TGT_ROM
		|-> $past(req_master) == addr_map_pkg::MST_SECONDARY
		&& $past(req_context) == `BOOT_CONTEXT)
		else $error("ROM fetch granted to wrong master or context");
	chk_sup_locked: assert property (req_valid && req_write
		&& lifecycle_secure && req_addr >= `SUPFLASH_BASE
		&& req_addr <= `SUPFLASH_LAST |=> rsp_error)
		else $error("supervisory flash write passed when secure");
	chk_low_power_write: assert property (rsp_valid && !rsp_error
		&& $past(req_write) && rsp_target == addr_map_pkg::TGT_MFLASH
		|-> !$past(ultra_low_power_mode))
		else $error("flash write granted in ultra-low-power mode");
	chk_row_aligned: assert property (rsp_valid && !rsp_error
		&& $past(req_write) && rsp_target == addr_map_pkg::TGT_MFLASH
		|-> (rsp_offset & ROW_MASK) == 32'h0)
		else $error("flash row write not on a row boundary");
	chk_serial_fetch: assert property (req_valid && req_fetch
		&& req_addr >= `EXT_BASE && req_addr <= `EXT_LAST && rights[2]
		|=> !rsp_error && rsp_target == addr_map_pkg::TGT_SERIAL)
		else $error("fetch from serial memory window refused");
	chk_hib_no_sram: assert property (hibernate
		|=> sram_block_on == '0)
		else $error("SRAM block kept powered in hibernate");
	chk_rsp_latency: assert property (req_valid |=> rsp_valid)
		else $error("request got no answer in one cycle");

endmodule // system_address_map_decoder

// ---- addr_map_defines.svh ----
// address map constants, field limits and sizes for the system decoder
`ifndef ADDR_MAP_DEFINES_SVH
`define ADDR_MAP_DEFINES_SVH

// ------------------------------------------------------------
// region bounds
// ------------------------------------------------------------
`define CODE_LAST      32'h1fff_ffff
`define DATA_BASE      32'h2000_0000
`define DATA_LAST      32'h3fff_ffff
`define PERI_BASE      32'h4000_0000
`define PERI_LAST      32'h5fff_ffff
`define EXT_BASE       32'h6000_0000
`define EXT_LAST       32'h9fff_ffff
`define PPB_BASE       32'he000_0000
`define PPB_LAST       32'he00f_ffff
`define SYS_BASE       32'he010_0000

// ------------------------------------------------------------
// memories inside the code region
// ------------------------------------------------------------
`define ROM_BASE       32'h0000_0000
`define ROM_LAST       32'h0001_ffff
`define SRAM_BASE      32'h0800_0000
`define SRAM_LAST      32'h0804_7fff
`define MFLASH_BASE    32'h1000_0000
`define MFLASH_LAST    32'h100f_ffff
`define AFLASH_BASE    32'h1400_0000
`define AFLASH_LAST    32'h1400_7fff
`define SUPFLASH_BASE  32'h1600_0000
`define SUPFLASH_LAST  32'h1600_7fff

// ------------------------------------------------------------
// sizes and counts
// ------------------------------------------------------------
`define FLASH_ROW_BYTES   512
`define FLASH_LINE_BITS   128
`define FLASH_SECTOR_KB   256
`define SRAM_BLOCK_KB     32
`define SRAM_BLOCKS       9
`define FUSE_BITS         1024
`define FUSE_SYS_BITS     512
`define CONTEXTS          8
`define BOOT_CONTEXT      3'h0
`define RIGHTS_RESET      3'h7

`endif

// ---- addr_map_pkg.sv ----
// types shared by the address map decoder and its helpers
package addr_map_pkg;

	typedef enum logic [1:0] {
		MST_PRIMARY   = 2'h0,
		MST_SECONDARY = 2'h1,
		MST_DEBUG     = 2'h2,
		MST_OTHER     = 2'h3
	} master_t;

	typedef enum logic [3:0] {
		TGT_NONE     = 4'h0,
		TGT_ROM      = 4'h1,
		TGT_SRAM     = 4'h2,
		TGT_MFLASH   = 4'h3,
		TGT_AFLASH   = 4'h4,
		TGT_SUPFLASH = 4'h5,
		TGT_PERIPH   = 4'h6,
		TGT_SERIAL   = 4'h7,
		TGT_PRIVATE  = 4'h8,
		TGT_SYSREG   = 4'h9
	} target_t;

	typedef enum logic [2:0] {
		FLT_NONE     = 3'h0,
		FLT_UNMAPPED = 3'h1,
		FLT_EXEC     = 3'h2,
		FLT_ROM_EXEC = 3'h3,
		FLT_RIGHTS   = 3'h4,
		FLT_SUP_LOCK = 3'h5,
		FLT_LOW_VOLT = 3'h6,
		FLT_ROW      = 3'h7
	} fault_t;

	typedef enum logic [2:0] {
		SF_IDLE = 3'b001,
		SF_NMI  = 3'b010,
		SF_RUN  = 3'b100
	} sf_state_t;

endpackage

// ---- context_rights_table.sv ----
// per context, per master, per privilege access rights table
`timescale 1ns/1ps
`include "addr_map_defines.svh"

module context_rights_table #(
	parameter int CONTEXTS = `CONTEXTS
) (
	input  wire logic                    ref_clk,
	input  wire logic                    sys_rst,
	input  wire logic                    cfg_valid,
	input  wire logic [2:0]              cfg_src_context,
	input  wire logic [2:0]              cfg_context,
	input  wire addr_map_pkg::master_t   cfg_master,
	input  wire logic                    cfg_priv,
	input  wire logic [2:0]              cfg_rights,
	input  wire logic [2:0]              look_context,
	input  wire addr_map_pkg::master_t   look_master,
	input  wire logic                    look_priv,
	output logic      [2:0]              look_rights
);
	localparam int ENTRIES = CONTEXTS * 8;

	logic [2:0] rights_reg  [ENTRIES];
	logic [2:0] rights_next [ENTRIES];
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;

	assign wr_idx = {cfg_context, cfg_master, cfg_priv};
	assign rd_idx = {look_context, look_master, look_priv};

	// boot context keeps full rights, so boot code can never lock itself out
	assign look_rights = (look_context == `BOOT_CONTEXT) ? `RIGHTS_RESET
	                                                     : rights_reg[rd_idx];

	always_comb begin
		for (int i = 0; i < ENTRIES; i++) begin
			rights_next[i] = rights_reg[i];
		end
		if (cfg_valid && cfg_src_context == `BOOT_CONTEXT) begin
			rights_next[wr_idx] = cfg_rights;
		end
	end

	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < ENTRIES; i++) begin
			rights_reg[i] <= sys_rst ? `RIGHTS_RESET : rights_next[i];
		end
	end

endmodule // context_rights_table

// ---- fuse_array_otp.sv ----
// one-time-programmable fuse array, bits only ever go from 0 to 1
`timescale 1ns/1ps
`include "addr_map_defines.svh"

module fuse_array_otp #(
	parameter int FUSE_BITS = `FUSE_BITS,
	parameter int SYS_BITS  = `FUSE_SYS_BITS
) (
	input  wire logic                    ref_clk,
	input  wire logic                    sys_rst,
	input  wire logic                    prog_valid,
	input  wire logic                    prog_boot_ctx,
	input  wire logic [9:0]              prog_index,
	input  wire logic [9:0]              rd_index,
	output logic                         rd_bit
);
	logic [FUSE_BITS-1:0] fuse_reg;
	logic [FUSE_BITS-1:0] fuse_next;
	logic                 rd_bit_next;

	for (genvar i = 0; i < FUSE_BITS; i++) begin : g_fuse
		always_comb begin
			fuse_next[i] = fuse_reg[i] | (prog_valid && prog_index == i
			               && (i >= SYS_BITS || prog_boot_ctx));
		end
	end

	assign rd_bit_next = fuse_reg[rd_index];

	// reset stands in for blank silicon in simulation only
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			fuse_reg <= '0;
			rd_bit   <= 1'b0;
		end else begin
			fuse_reg <= fuse_next;
			rd_bit   <= rd_bit_next;
		end
	end

	chk_fuse_one_way: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(fuse_reg & $past(fuse_reg)) == $past(fuse_reg))
		else $error("fuse bit went back to zero");

endmodule // fuse_array_otp

// ---- secondary_cpu_model.sv ----
// behavioural secondary processor that serves system-function interrupts
`timescale 1ns/1ps

module secondary_cpu_model #(
	parameter int LATENCY = 5
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic nmi_secondary,
	output logic      sf_done
);
	int cnt = 0;

	// run the function, then report done
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt <= 0;
			sf_done <= 1'b0;
		end else begin
			sf_done <= (cnt == 1);
			if (nmi_secondary)
				cnt <= LATENCY;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule // secondary_cpu_model

// ---- testbench.sv ----
// self-checking bench for the system address map decoder
`timescale 1ns/1ps

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t %h %h", $time, (a), (b)); end end

module testbench;
	typedef struct {
		logic [31:0] a;
		logic w, f;
		logic [1:0] m;
		logic [2:0] c;
		logic p, u, s, e;
		logic [3:0] t;
		logic [2:0] k;
		logic [31:0] o;
	} row_t;

	logic ref_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
	logic [31:0] req_addr = 32'h0;
	logic req_write = 1'b0, req_fetch = 1'b0, req_priv = 1'b0;
	addr_map_pkg::master_t req_master = addr_map_pkg::MST_PRIMARY;
	addr_map_pkg::master_t cfg_master = addr_map_pkg::MST_PRIMARY;
	logic [2:0] req_context = 3'h0, cfg_context = 3'h0, cfg_rights = 3'h0;
	logic ultra_low_power_mode = 1'b0, lifecycle_secure = 1'b0;
	logic cfg_valid = 1'b0;
	logic deep_sleep = 1'b0, hibernate = 1'b0, cfg_priv = 1'b0;
	logic [8:0] sram_retain_mask = 9'h0;
	logic sf_req_primary = 1'b0, sf_req_secondary = 1'b0;
	logic sf_req_debug = 1'b0, fuse_prog_valid = 1'b0;
	logic [9:0] fuse_prog_index = 10'h0, fuse_rd_index = 10'h0;
	logic rsp_valid, rsp_error, nmi_secondary, sf_busy, fuse_rd_bit, sf_done;
	addr_map_pkg::target_t rsp_target;
	addr_map_pkg::fault_t rsp_fault;
	logic [31:0] rsp_offset;
	logic [27:0] flash_line;
	logic [8:0] sram_block_on;
	int failures = 0, n_checks = 0;

	system_address_map_decoder system_address_map_decoder_inst (.*);
	secondary_cpu_model secondary_cpu_model_inst (.*);

	initial forever #5 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// ordinary accesses: a w f m c p u s -> error target fault offset
	// ------------------------------------------------------------
	row_t rows[29] = '{
		'{32'h0000_0100,0,0,0,0,0,0,0, 0,1,0,32'h100},
		'{32'h0001_ffff,0,0,0,0,0,0,0, 0,1,0,32'h1ffff},
		'{32'h0002_0000,0,0,0,0,0,0,0, 1,0,1,0},
		'{32'h0800_0000,0,1,0,0,0,0,0, 0,2,0,0},
		'{32'h0804_7fff,0,0,1,0,0,0,0, 0,2,0,32'h47fff},
		'{32'h0804_8000,0,0,0,0,0,0,0, 1,0,1,0},
		'{32'h1000_0200,1,0,0,0,0,0,0, 0,3,0,32'h200},
		'{32'h100f_fff0,0,0,0,0,0,0,0, 0,3,0,32'hffff0},
		'{32'h1010_0000,0,0,0,0,0,0,0, 1,0,1,0},
		'{32'h1400_7fff,0,0,0,0,0,0,0, 0,4,0,32'h7fff},
		'{32'h1600_0000,1,0,0,0,0,0,0, 0,5,0,0},
		'{32'h1600_0000,1,0,0,0,0,0,1, 1,0,5,0},
		'{32'h1600_0010,0,0,0,0,0,0,1, 0,5,0,32'h10},
		'{32'h1600_0200,1,0,0,0,0,1,1, 1,0,5,0},
		'{32'h2000_0000,0,0,0,0,0,0,0, 1,0,1,0},
		'{32'h4000_0010,0,0,1,0,0,0,0, 0,6,0,32'h10},
		'{32'h4000_0010,0,1,0,0,0,0,0, 1,0,2,0},
		'{32'h6000_0000,0,1,0,0,0,0,0, 0,7,0,0},
		'{32'h9fff_ffff,0,0,0,0,0,0,0, 0,7,0,32'h3fffffff},
		'{32'ha000_0000,0,0,0,0,0,0,0, 1,0,1,0},
		'{32'he000_1000,0,0,1,0,0,0,0, 0,8,0,32'h1000},
		'{32'he010_0000,0,0,0,0,0,0,0, 0,9,0,0},
		'{32'h0000_0000,0,1,1,0,0,0,0, 0,1,0,0},
		'{32'h0000_0000,0,1,0,0,0,0,0, 1,0,3,0},
		'{32'h0000_0000,0,1,1,1,0,0,0, 1,0,3,0},
		'{32'h1000_0100,1,0,0,0,0,0,0, 1,0,7,0},
		'{32'h1000_0000,1,0,0,0,0,1,0, 1,0,6,0},
		'{32'h1000_0000,0,0,0,0,0,1,0, 0,3,0,0},
		'{32'h0800_0100,0,0,0,2,1,0,0, 0,2,0,32'h100}
	};

	task end_sim;
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one request, answer checked in the following cycle
	task go(input row_t r);
		@(negedge ref_clk);
		req_valid = 1'b1;
		req_addr = r.a;
		req_write = r.w;
		req_fetch = r.f;
		req_master = addr_map_pkg::master_t'(r.m);
		req_context = r.c;
		req_priv = r.p;
		ultra_low_power_mode = r.u;
		lifecycle_secure = r.s;
		@(negedge ref_clk);
		`CHK(rsp_valid, 1'b1)
		`CHK(rsp_error, r.e)
		`CHK(rsp_target, r.t)
		`CHK(rsp_fault, r.k)
		`CHK(rsp_offset, r.o)
	endtask

	task cfg(input logic [2:0] src, ctx, input logic [2:0] rt);
		@(negedge ref_clk);
		req_valid = 1'b0;
		req_context = src;
		cfg_context = ctx;
		cfg_rights = rt;
		cfg_valid = 1'b1;
		@(negedge ref_clk);
		cfg_valid = 1'b0;
	endtask

	task fuse(input logic [2:0] src, input logic [9:0] idx, input logic exp);
		@(negedge ref_clk);
		req_valid = 1'b0;
		req_context = src;
		fuse_prog_index = idx;
		fuse_rd_index = idx;
		fuse_prog_valid = 1'b1;
		@(negedge ref_clk);
		fuse_prog_valid = 1'b0;
		@(negedge ref_clk);
		`CHK(fuse_rd_bit, exp)
	endtask

	task rst;
		sys_rst = 1'b1;
		repeat (6) @(negedge ref_clk);
		sys_rst = 1'b0;
		`CHK(rsp_valid, 1'b0)
		`CHK(sf_busy, 1'b0)
		`CHK(sram_block_on, 9'h1ff)
		`CHK(fuse_rd_bit, 1'b0)
	endtask

	initial begin
		rst();
		for (int i = 0; i < 29; i++) begin
			go(rows[i]);
			if (i == 6) `CHK(flash_line, 28'h100_0020)
			if (i == 8) `CHK(flash_line, 28'h100_ffff)
		end
		@(negedge ref_clk);
		req_valid = 1'b0;
		@(negedge ref_clk);
		`CHK(rsp_valid, 1'b0)
		// ------------------------------------------------------------
		// rights, fuses, system functions, power, second reset
		// ------------------------------------------------------------
		cfg(3'h0, 3'h2, 3'h0);
		go('{32'h0800_0000,0,0,0,2,0,0,0, 1,0,4,0});
		go('{32'h0800_0000,0,0,0,2,1,0,0, 0,2,0,0});
		cfg(3'h1, 3'h3, 3'h0);
		go('{32'h0800_0000,0,0,0,3,0,0,0, 0,2,0,0});
		cfg(3'h0, 3'h0, 3'h0);
		go('{32'h0800_0000,0,0,0,0,0,0,0, 0,2,0,0});
		fuse(3'h1, 10'd600, 1'b1);
		fuse(3'h1, 10'd5, 1'b0);
		fuse(3'h0, 10'd5, 1'b1);
		fuse(3'h1, 10'd511, 1'b0);
		fuse(3'h1, 10'd1023, 1'b1);
		for (int i = 0; i < 3; i++) begin
			@(negedge ref_clk);
			{sf_req_debug, sf_req_secondary, sf_req_primary} = 3'h1 << i;
			@(negedge ref_clk);
			{sf_req_debug, sf_req_secondary, sf_req_primary} = 3'h0;
			`CHK(nmi_secondary, 1'b1)
			`CHK(sf_busy, 1'b1)
			@(negedge ref_clk);
			`CHK(nmi_secondary, 1'b0)
			sf_req_primary = 1'b1;
			@(negedge ref_clk);
			sf_req_primary = 1'b0;
			`CHK(nmi_secondary, 1'b0)
			for (int n = 0; sf_busy !== 1'b0; n++) begin
				if (n > 20) begin
					failures++;
					end_sim();
				end
				@(negedge ref_clk);
			end
		end
		deep_sleep = 1'b1;
		sram_retain_mask = 9'h103;
		@(negedge ref_clk);
		`CHK(sram_block_on, 9'h103)
		hibernate = 1'b1;
		@(negedge ref_clk);
		`CHK(sram_block_on, 9'h000)
		deep_sleep = 1'b0;
		hibernate = 1'b0;
		rst();
		go('{32'h0800_0000,0,0,0,2,0,0,0, 0,2,0,0});
		end_sim();
	end
endmodule // testbench
